// *** hdl/quarter_gen.sv ***
// Quarter-phase sequencer of the instruction cycle
`timescale 1ns/10ps
module quarter_gen
   import stack_ops_pkg::*;
(
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   output quarter_t      phase_o
);
   // ==========================================================
   // Four quarters per instruction cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         phase_o <= Q1;
      else
         phase_o <= quarter_t'(phase_o + 2'd1);
   end
endmodule

// *** hdl/stack_ops_exec.sv ***
// Execution of stack pop, push, call-through-working-register and indexed move
// ==========================================================
`timescale 1ns/10ps
`include "stack_ops_params.svh"
module stack_ops_exec
   import stack_ops_pkg::*;
#(
   parameter int DEPTH = `STACK_DEPTH
)
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic [15:0]         instr_i,
   input  wire logic                instr_valid_i,
   input  wire logic [`PC_W-1:0]    pc_i,
   input  wire logic [7:0]          working_register_i,
   input  wire logic [7:0]          counter_latch_high_i,
   input  wire logic [7:0]          counter_latch_upper_i,
   input  wire logic [11:0]         pointer_register_two_i,
   input  wire logic [7:0]          mem_rdata_i,
   output logic [1:0]               phase_o,
   output logic                     busy_o,
   output logic                     pc_load_o,
   output logic [`PC_W-1:0]         pc_target_o,
   output logic [`PC_W-1:0]         top_of_stack_o,
   output logic [4:0]               stack_ptr_o,
   output logic                     mem_rd_o,
   output logic [`ADDR_W-1:0]       mem_raddr_o,
   output logic                     mem_we_o,
   output logic [`ADDR_W-1:0]       mem_waddr_o,
   output logic [7:0]               mem_wdata_o,
   output logic                     illegal_dest_o
);
   // ==========================================================
   // Phase and decode
   quarter_t              phase;
   exec_state_t           state;
   logic [`PC_W-1:0]      stack_mem [DEPTH];
   logic [4:0]            sp;
   logic [`ADDR_W-1:0]    src_addr;
   logic [7:0]            move_byte;
   logic                  cyc_start;
   logic                  is_pop;
   logic                  is_push;
   logic                  is_call_working;
   logic                  is_indexed_move;
   logic                  call_act;
   logic [`PC_W-1:0]      ret_addr;

   function automatic logic in_indirect(input logic [`ADDR_W-1:0] a);
      in_indirect = (a >= `INDF_LO) && (a <= `INDF_HI);
   endfunction

   function automatic logic protected_dest(input logic [`ADDR_W-1:0] a);
      protected_dest = (a == `ADDR_PC_LOW)
                       || ((a >= `ADDR_STACK_LOW) && (a <= `ADDR_STACK_UPPER));
   endfunction

   quarter_gen u_quarter
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .phase_o (phase)
   );

   assign cyc_start = instr_valid_i && (state == ST_IDLE);
   assign is_pop    = cyc_start && (instr_i == `OPC_POP);
   assign is_push   = cyc_start && (instr_i == `OPC_PUSH);
   assign is_call_working = cyc_start && (instr_i == `OPC_CALL_WORKING);
   assign is_indexed_move = cyc_start && (instr_i[15:7] == `OPC_INDEXED_HI);
   assign ret_addr  = pc_i + `PC_STEP;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         phase_o <= 2'h0;
      else
         phase_o <= phase;
   end

   // ==========================================================
   // Sequencer; decode is taken in Q1 only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state <= ST_IDLE;
      else
         unique case (state)
            ST_IDLE:
            begin
               if (phase == Q1 && is_call_working)
                  state <= ST_CALL_NOP;
               else if (phase == Q1 && is_indexed_move)
                  state <= ST_MOVE_FETCH;
            end
            ST_CALL_NOP:
            begin
               // First Q4 still closes cycle one; the second ends the idle cycle
               if (phase == Q4 && !call_act)
                  state <= ST_IDLE;
            end
            ST_MOVE_FETCH:
            begin
               if (phase == Q4)
                  state <= ST_MOVE_WRITE;
            end
            ST_MOVE_WRITE:
            begin
               if (phase == Q4)
                  state <= ST_IDLE;
            end
         endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         busy_o <= 1'b0;
      else if (phase == Q4)
         busy_o <= (state == ST_MOVE_FETCH) || call_act;
   end

   // Call in its first cycle; state has left idle before Q2, so push runs off this
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         call_act <= 1'b0;
      else if (phase == Q1 && is_call_working)
         call_act <= 1'b1;
      else if (phase == Q4)
         call_act <= 1'b0;
   end

   // ==========================================================
   // Return stack; overflow wraps silently, no error detection here
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sp <= 5'h00;
      else if (phase == Q2 && (is_push || call_act))
      begin
         sp <= sp + 5'h01;
         stack_mem[sp] <= ret_addr;
      end
      else if (phase == Q3 && is_pop && sp != 5'h00)
         sp <= sp - 5'h01;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stack_ptr_o    <= 5'h00;
         top_of_stack_o <= '0;
      end
      else
      begin
         stack_ptr_o    <= sp;
         top_of_stack_o <= (sp == 5'h00) ? '0 : stack_mem[sp - 5'h01];
      end
   end

   // ==========================================================
   // Call target; no shadow copies are taken
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pc_load_o   <= 1'b0;
         pc_target_o <= '0;
      end
      else
      begin
         pc_load_o <= (phase == Q4) && call_act;
         if (phase == Q2 && call_act)
            pc_target_o <= {counter_latch_upper_i[4:0],
                            counter_latch_high_i,
                            working_register_i};
      end
   end

   // ==========================================================
   // Indexed to absolute move
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         src_addr <= '0;
      else if (phase == Q1 && is_indexed_move)
         src_addr <= pointer_register_two_i
                     + {5'h00, instr_i[`OFFSET_MSB:0]};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mem_rd_o    <= 1'b0;
         mem_raddr_o <= '0;
      end
      else
      begin
         mem_rd_o    <= (state == ST_MOVE_FETCH) && (phase == Q3);
         mem_raddr_o <= src_addr;
      end
   end

   // Read data arrives with the read strobe; a source in the indirect window is still read from memory but stored as zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         move_byte <= 8'h00;
      else if (mem_rd_o)
         move_byte <= in_indirect(mem_raddr_o) ? `ZERO_BYTE : mem_rdata_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mem_we_o       <= 1'b0;
         mem_waddr_o    <= '0;
         mem_wdata_o    <= 8'h00;
         illegal_dest_o <= 1'b0;
      end
      else
      begin
         mem_we_o <= (state == ST_MOVE_WRITE) && (phase == Q3)
                     && !protected_dest(instr_i[`DEST_MSB:0]);
         illegal_dest_o <= (state == ST_MOVE_WRITE) && (phase == Q3)
                     && protected_dest(instr_i[`DEST_MSB:0]);
         if (state == ST_MOVE_WRITE && phase == Q3)
         begin
            mem_waddr_o <= instr_i[`DEST_MSB:0];
            mem_wdata_o <= move_byte;
         end
      end
   end
endmodule

// *** hdl/stack_ops_params.svh ***
// Constants for the return-stack and indexed-move execution block
`ifndef STACK_OPS_PARAMS_SVH
`define STACK_OPS_PARAMS_SVH
// ==========================================================
// Opcodes (full 16-bit first word, except OPC_INDEXED_HI which is bits 15:7)
`define OPC_POP          16'h0006
`define OPC_PUSH         16'h0005
`define OPC_CALL_WORKING 16'h0014
`define OPC_INDEXED_HI   9'h1D6
// ==========================================================
// Field positions
`define OFFSET_MSB       6
`define DEST_MSB         11
// ==========================================================
// Widths and sizes
`define PC_W             21
`define ADDR_W           12
`define STACK_DEPTH      31
`define PC_STEP          21'h000002
// ==========================================================
// Indirect-register window and reserved destinations
`define INDF_LO          12'hFD8
`define INDF_HI          12'hFEF
`define ADDR_PC_LOW      12'hFF9
`define ADDR_STACK_LOW   12'hFFD
`define ADDR_STACK_UPPER 12'hFFF
`define ZERO_BYTE        8'h00
`endif

// *** hdl/stack_ops_pkg.sv ***
// Types for the return-stack and indexed-move execution block
package stack_ops_pkg;
   // ==========================================================
   // Execution states and quarter phases
   typedef enum logic [1:0] {ST_IDLE, ST_CALL_NOP, ST_MOVE_FETCH, ST_MOVE_WRITE} exec_state_t;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;
endpackage

// *** verification/stack_ops_monitor.sv ***
// Concurrent checks on the stack and indexed-move execution block
`timescale 1ns/10ps
`include "stack_ops_params.svh"
module stack_ops_monitor
(
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                pc_load_o,
   input wire logic                mem_rd_o,
   input wire logic                mem_we_o,
   input wire logic                illegal_dest_o,
   input wire logic [4:0]          stack_ptr_o,
   input wire logic [7:0]          working_register_i,
   input wire logic [7:0]          counter_latch_high_i,
   input wire logic [7:0]          counter_latch_upper_i,
   input wire logic [7:0]          mem_rdata_i,
   input wire logic [7:0]          mem_wdata_o,
   input wire logic [`ADDR_W-1:0]  mem_raddr_o,
   input wire logic [`PC_W-1:0]    pc_target_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Properties
   property p_target;
      pc_load_o |-> pc_target_o ==
         {counter_latch_upper_i[4:0], counter_latch_high_i, working_register_i};
   endproperty
   property p_load_pulse;
      pc_load_o |=> !pc_load_o;
   endproperty
   property p_rd_to_we;
      mem_rd_o |-> ##4 (mem_we_o || illegal_dest_o);
   endproperty
   property p_we_cause;
      mem_we_o |-> $past(mem_rd_o, 4) && !illegal_dest_o;
   endproperty
   // A source in the indirect window must read back as zero
   property p_zero;
      mem_we_o && $past(mem_raddr_o, 4) inside {[`INDF_LO:`INDF_HI]} |-> mem_wdata_o == `ZERO_BYTE;
   endproperty
   property p_copy;
      mem_we_o && !($past(mem_raddr_o, 4) inside {[`INDF_LO:`INDF_HI]})
         |-> mem_wdata_o == $past(mem_rdata_i, 4);
   endproperty
   property p_sp_step;
      $changed(stack_ptr_o) |-> stack_ptr_o == $past(stack_ptr_o) + 5'h01
         || stack_ptr_o == $past(stack_ptr_o) - 5'h01;
   endproperty
   property p_rd_pulse;
      mem_rd_o |=> !mem_rd_o [*3];
   endproperty
   // ==========================================================
   // Assertions
   a_target: assert property (p_target) else $error("call target wrong");
   a_load_pulse: assert property (p_load_pulse) else $error("load not a pulse");
   a_rd_to_we: assert property (p_rd_to_we) else $error("write not 4 after read");
   a_we_cause: assert property (p_we_cause) else $error("write without read");
   a_zero: assert property (p_zero) else $error("indirect source not zero");
   a_copy: assert property (p_copy) else $error("moved byte wrong");
   a_sp_step: assert property (p_sp_step) else $error("stack depth jump");
   a_rd_pulse: assert property (p_rd_pulse) else $error("read repeated");
   c_load: cover property (pc_load_o);
   c_we: cover property (mem_we_o);
   c_ill: cover property (illegal_dest_o);
endmodule
bind stack_ops_exec stack_ops_monitor u_stack_ops_monitor (.clk_i(clk_i), .rst_i(rst_i),
   .pc_load_o(pc_load_o), .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o),
   .illegal_dest_o(illegal_dest_o), .stack_ptr_o(stack_ptr_o),
   .working_register_i(working_register_i), .counter_latch_high_i(counter_latch_high_i),
   .counter_latch_upper_i(counter_latch_upper_i), .mem_rdata_i(mem_rdata_i),
   .mem_wdata_o(mem_wdata_o), .mem_raddr_o(mem_raddr_o), .pc_target_o(pc_target_o));

// *** verification/test_return_stack_and_indexed_move_ops.sv ***
// Self-checking bench for the stack and indexed-move execution block
`timescale 1ns/10ps
`include "stack_ops_params.svh"
module test_return_stack_and_indexed_move_ops;
   typedef struct {logic [15:0] w; logic [20:0] pc; logic [20:0] top_of_stack; logic [4:0] sp;} row_t;
   logic        clk_i = 0, rst_i = 1, instr_valid_i = 0, pc_load_o, busy_o;
   logic        mem_rd_o, mem_we_o, illegal_dest_o;
   logic [15:0] instr_i = 0;
   logic [20:0] pc_i = 0, pc_target_o, top_of_stack_o;
   logic [7:0]  wr = 8'h06, lh = 8'h10, lu = 8'hE0, mem_rdata_i, mem_wdata_o, wdata;
   logic [11:0] ptr2 = 0, mem_raddr_o, mem_waddr_o, raddr, waddr;
   logic [4:0]  stack_ptr_o;
   logic [1:0]  phase_o;
   int          mismatches = 0, checks = 0, nrd, nwe, nill, nld, nbusy;
   // Last row pops an empty stack, which must be ignored
   row_t rows [5] = '{'{`OPC_PUSH, 21'h124, 21'h126, 1}, '{`OPC_PUSH, 21'h200, 21'h202, 2},
      '{`OPC_POP, 21'h300, 21'h126, 1}, '{`OPC_POP, 21'h310, 0, 0}, '{`OPC_POP, 21'h320, 0, 0}};
   stack_ops_exec u_stack_ops_exec (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .pc_i(pc_i), .working_register_i(wr),
      .counter_latch_high_i(lh), .counter_latch_upper_i(lu), .pointer_register_two_i(ptr2),
      .mem_rdata_i(mem_rdata_i), .phase_o(phase_o), .busy_o(busy_o), .pc_load_o(pc_load_o),
      .pc_target_o(pc_target_o), .top_of_stack_o(top_of_stack_o), .stack_ptr_o(stack_ptr_o),
      .mem_rd_o(mem_rd_o), .mem_raddr_o(mem_raddr_o), .mem_we_o(mem_we_o),
      .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .illegal_dest_o(illegal_dest_o));
   // ==========================================================
   // Clock, memory and pulse capture
   initial forever #2 clk_i = ~clk_i;
   assign mem_rdata_i = (mem_raddr_o == 12'h085) ? 8'h33 : 8'h55;
   always @(negedge clk_i)
   begin
      nbusy += (busy_o === 1'b1);
      nld += (pc_load_o === 1'b1);
      nill += (illegal_dest_o === 1'b1);
      if (mem_rd_o === 1'b1) begin nrd++; raddr = mem_raddr_o; end
      if (mem_we_o === 1'b1) begin nwe++; waddr = mem_waddr_o; wdata = mem_wdata_o; end
   end
   // ==========================================================
   // Tasks
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits for internal Q4 so the word lands at Q1; bounded search
   task automatic exec(input logic [15:0] w1, input logic [15:0] w2, input logic [20:0] pc,
                       input int cyc);
      int n;
      n = 0;
      do @(negedge clk_i); while (phase_o !== 2'd2 && ++n < 20);
      if (n >= 20) begin mismatches++; summarize(); end
      nrd = 0; nwe = 0; nill = 0; nld = 0; nbusy = 0;
      @(posedge clk_i);
      instr_i <= w1; instr_valid_i <= 1'b1; pc_i <= pc;
      repeat (4) @(posedge clk_i);
      if (cyc == 2)
      begin
         instr_i <= w2;
         repeat (4) @(posedge clk_i);
      end
      instr_i <= 16'h0000; instr_valid_i <= 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic mv(input logic [11:0] f, input logic [6:0] z, input logic [11:0] d,
                     input logic [11:0] ra, input logic [7:0] wd, input int we);
      @(posedge clk_i);
      ptr2 <= f;
      exec({9'h1D6, z}, {4'hF, d}, 21'h000600, 2);
      check(nrd, 1);
      check(raddr, ra);
      check(nwe, we);
      check(nill, 1 - we);
      if (we == 1) check(waddr, d);
      if (we == 1) check(wdata, wd);
      $display("move test from %h done", ra);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check({busy_o, pc_load_o, mem_we_o, stack_ptr_o, top_of_stack_o, phase_o}, 0);
      foreach (rows[i])
      begin
         exec(rows[i].w, 16'h0000, rows[i].pc, 1);
         check(top_of_stack_o, rows[i].top_of_stack);
         check(stack_ptr_o, rows[i].sp);
         $display("row %0d done", i);
      end
      exec(`OPC_CALL_WORKING, 16'h0000, 21'h000400, 2);
      check(top_of_stack_o, 21'h000402);
      check(stack_ptr_o, 1);
      check(pc_target_o, 21'h001006);
      check(nld, 1);
      check(nbusy, 4);
      $display("call test done");
      // Mid-run reset must empty the stack again
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check({busy_o, pc_load_o, stack_ptr_o, top_of_stack_o, phase_o}, 0);
      $display("reset test done");
      mv(12'h080, 7'h05, 12'h123, 12'h085, 8'h33, 1);
      mv(12'hFD0, 7'h0A, 12'hFFC, 12'hFDA, 8'h00, 1);
      mv(12'hF80, 7'h7F, 12'hFF9, 12'hFFF, 8'h00, 0);
      summarize();
   end
endmodule
